// ==== cpu_model.sv ====
// Model of the CPU core issuing register accesses and instructions
`timescale 1ns/1ns
module cpu_model (
  input  wire       clk_i,
  input  wire [7:0] rdata_i,
  output reg  [7:0] addr_o,
  output reg  [7:0] wdata_o,
  output reg        wr_en_o,
  output reg        rd_en_o,
  output reg  [3:0] ops_o
);
  // Idle bus at time zero
  initial begin
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    ops_o   = 4'h0;
  end
  // One-cycle write; data scrambled once released
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk_i);
      addr_o  = a;
      wdata_o = d;
      wr_en_o = 1'b1;
      @(negedge clk_i);
      wr_en_o = 1'b0;
      wdata_o = ~d;
    end
  endtask
  // One-cycle read; data taken after the sampling edge
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge clk_i);
      addr_o  = a;
      rd_en_o = 1'b1;
      @(negedge clk_i);
      rd_en_o = 1'b0;
      d       = rdata_i;
    end
  endtask
  // Instruction pulse: stop, wait, wake, return
  task op(input [3:0] v);
    begin
      @(negedge clk_i);
      ops_o = v;
      @(negedge clk_i);
      ops_o = 4'h0;
    end
  endtask
endmodule // cpu_model

// ==== lvd_hysteresis.v ====
// Low-voltage hold latch with separate fall and rise thresholds
`timescale 1ns/1ns

module lvd_hysteresis (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        enable_i,
  input  wire        below_fall_i,
  input  wire        above_rise_i,
  output reg         hold_o
);

  reg  hold_next;

  // Enter hold below the lower threshold, leave above the upper one or when enable_i is low
  always @* begin
    hold_next = hold_o;
    if (!enable_i) begin
      hold_next = 1'b0;
    end else if (below_fall_i) begin
      hold_next = 1'b1;
    end else if (above_rise_i) begin
      hold_next = 1'b0;
    end
  end

  // Starts held; the first clock with enable_i low releases it, whatever the thresholds say
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_o <= 1'b1;
    end else begin
      hold_o <= hold_next;
    end
  end

endmodule // lvd_hysteresis

// ==== watchdog_and_reset_control.v ====
// Digital watchdog, reset sequencing and stop/wait control
`timescale 1ns/1ns
`include "wdg_rst_defs.vh"

module watchdog_and_reset_control (
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Data-space register access
  input  wire [7:0]  addr_i,
  input  wire        wr_en_i,
  input  wire        rd_en_i,
  input  wire [7:0]  wdata_i,
  output wire [7:0]  rdata_o,
  // Option straps
  input  wire        opt_hw_activation_i,
  input  wire        opt_ext_stop_i,
  input  wire        opt_lvd_en_i,
  // Low-voltage comparators
  input  wire        lvd_below_fall_i,
  input  wire        lvd_above_rise_i,
  // Open-drain reset pin
  input  wire        rst_pin_i,
  output wire        rst_pin_o,
  output wire        rst_pin_oe_o,
  // CPU side
  input  wire        nmi_pin_i,
  input  wire        stop_instr_i,
  input  wire        wait_instr_i,
  input  wire        wake_irq_i,
  input  wire        return_from_interrupt_i,
  input  wire        irq_pending_i,
  output wire        cpu_rst_o,
  output wire        stack_clear_o,
  output wire        pc_load_o,
  output wire [11:0] pc_vector_o,
  output wire        nmi_mode_o,
  output wire        service_pending_o,
  output wire        wait_mode_o,
  output wire        stop_mode_o,
  output wire        wdg_active_o
);

  // One-hot sequencer states
  localparam [4:0] ST_RESET = 5'b00001;
  localparam [4:0] ST_DELAY = 5'b00010;
  localparam [4:0] ST_RUN   = 5'b00100;
  localparam [4:0] ST_WAIT  = 5'b01000;
  localparam [4:0] ST_STOP  = 5'b10000;
  reg  [4:0]  state_reg;
  reg  [4:0]  state_next;
  reg  [4:0]  stretch_reg;
  reg  [4:0]  stretch_next;
  reg  [11:0] stab_reg;
  reg  [11:0] stab_next;
  reg         cause_int_reg;
  reg         cause_int_next;
  reg         pin_drive_reg;
  reg         cpu_rst_reg;
  reg         pc_load_reg;
  reg         int_flag_reg;
  reg         service_reg;
  reg  [7:0]  rdata_reg;
  reg         opt_hw_reg;
  reg         opt_ext_stop_reg;
  reg         opt_lvd_reg;
  // Watchdog physical counter and control bit
  reg  [6:0]  cnt_reg;
  reg  [6:0]  cnt_next;
  reg         c_reg;
  reg         c_next;
  reg         wdg_trip_reg;
  reg         wdg_trip_next;
  reg         sw_trip_reg;
  reg         sw_trip_next;
  reg  [6:0]  cnt_dec;
  reg  [7:0]  reg_view;
  reg  [6:0]  wr_cnt;
  wire        lvd_hold;
  wire        wdg_tick;
  wire        c_eff;
  wire        counting;
  wire        wr_hit;
  wire        internal_src;
  wire        ext_low;
  integer     i;

  lvd_hysteresis u_lvd (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .enable_i     (opt_lvd_reg),
    .below_fall_i (lvd_below_fall_i),
    .above_rise_i (lvd_above_rise_i),
    .hold_o       (lvd_hold)
  );

  // Decrement period divider, frozen outside run and wait
  wdt_prescaler u_pre (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clear_i (wr_hit | state_reg[0]),
    .run_i   (counting),
    .tick_o  (wdg_tick)
  );

  // Control bit as the rest of the block sees it
  assign c_eff        = c_reg;
  assign counting     = state_reg[2] | state_reg[3];
  assign wr_hit       = wr_en_i & (addr_i == `WDG_ADDR) & state_reg[2];
  assign internal_src = lvd_hold | wdg_trip_reg | sw_trip_reg;
  // Pin reads low only from an outside driver while this end releases it
  assign ext_low      = ~rst_pin_i & ~pin_drive_reg;

  always @* begin
    reg_view = 8'h00;
    wr_cnt   = 7'h00;
    for (i = 0; i < 6; i = i + 1) begin
      reg_view[`WDG_T0_BIT - i] = cnt_reg[i];
      wr_cnt[i]                 = wdata_i[`WDG_T0_BIT - i];
    end
    reg_view[`WDG_SR_BIT] = cnt_reg[`WDG_CNT_TOP_BIT];
    reg_view[`WDG_C_BIT]  = c_eff;
    wr_cnt[6]             = wdata_i[`WDG_SR_BIT];
  end

  // Counter, control bit and trip detection
  always @* begin
    cnt_next      = cnt_reg;
    c_next        = c_reg;
    wdg_trip_next = 1'b0;
    sw_trip_next  = 1'b0;
    cnt_dec       = cnt_reg - 7'h01;
    if (state_reg[0]) begin
      cnt_next = `WDG_CNT_RESET;
      c_next   = opt_hw_activation_i;
    end else if (wr_hit) begin
      cnt_next = wr_cnt;
      c_next   = c_reg | wdata_i[`WDG_C_BIT];
      sw_trip_next = ~wdata_i[`WDG_SR_BIT];
    end else if (wdg_tick) begin
      cnt_next = cnt_dec;
      wdg_trip_next = c_eff & cnt_reg[`WDG_CNT_TOP_BIT] & ~cnt_dec[`WDG_CNT_TOP_BIT];
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg      <= `WDG_CNT_RESET;
      c_reg        <= 1'b0;
      wdg_trip_reg <= 1'b0;
      sw_trip_reg  <= 1'b0;
    end else begin
      cnt_reg      <= cnt_next;
      c_reg        <= c_next;
      wdg_trip_reg <= wdg_trip_next;
      sw_trip_reg  <= sw_trip_next;
    end
  end

  // Reset, stabilisation, run, wait and stop sequencing
  always @* begin
    state_next     = state_reg;
    stretch_next   = stretch_reg;
    stab_next      = stab_reg;
    cause_int_next = cause_int_reg;
    if (internal_src | ext_low) begin
      state_next     = ST_RESET;
      stretch_next   = 5'h00;
      cause_int_next = cause_int_reg | internal_src;
    end else begin
      case (state_reg)
        ST_RESET: begin
          if (stretch_reg == `RST_STRETCH_LAST) begin
            state_next     = ST_DELAY;
            stab_next      = 12'h000;
            cause_int_next = 1'b0;
          end else begin
            stretch_next = stretch_reg + 5'h01;
          end
        end
        ST_DELAY: begin
          if (stab_reg == `STAB_DELAY_LAST) begin
            state_next = ST_RUN;
          end else begin
            stab_next = stab_reg + 12'h001;
          end
        end
        ST_RUN: begin
          if (stop_instr_i) begin
            if (!c_eff) begin
              state_next = ST_STOP;
            end else if (opt_hw_reg & opt_ext_stop_reg & nmi_pin_i) begin
              state_next = ST_STOP;
            end else begin
              state_next = ST_WAIT;
            end
          end else if (wait_instr_i) begin
            state_next = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (wake_irq_i) begin
            state_next = ST_RUN;
          end
        end
        ST_STOP: begin
          if (wake_irq_i) begin
            state_next = ST_RUN;
          end
        end
        default: begin
          state_next = ST_RESET;
        end
      endcase
    end
  end

  // Sequencer storage; power-on counts as an internal source
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg     <= ST_RESET;
      stretch_reg   <= 5'h00;
      stab_reg      <= 12'h000;
      cause_int_reg <= 1'b1;
    end else begin
      state_reg     <= state_next;
      stretch_reg   <= stretch_next;
      stab_reg      <= stab_next;
      cause_int_reg <= cause_int_next;
    end
  end

  // Option straps are caught while the device sits in reset
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opt_hw_reg       <= 1'b0;
      opt_ext_stop_reg <= 1'b0;
      opt_lvd_reg      <= 1'b0;
    end else if (state_reg[0]) begin
      opt_hw_reg       <= opt_hw_activation_i;
      opt_ext_stop_reg <= opt_ext_stop_i;
      opt_lvd_reg      <= opt_lvd_en_i;
    end
  end

  // Pin drive and CPU reset controls
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_drive_reg <= 1'b1;
      cpu_rst_reg   <= 1'b1;
      pc_load_reg   <= 1'b0;
    end else begin
      pin_drive_reg <= state_next[0] & cause_int_next;
      cpu_rst_reg   <= state_next[0] | state_next[1];
      pc_load_reg   <= state_reg[1] & state_next[2];
    end
  end

  // Interrupt flag: reset sets it, return clears it, reset wins
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_flag_reg <= 1'b1;
      service_reg  <= 1'b0;
    end else if (state_reg[0] | state_reg[1]) begin
      int_flag_reg <= 1'b1;
      service_reg  <= 1'b0;
    end else begin
      if (return_from_interrupt_i) begin
        int_flag_reg <= 1'b0;
      end
      service_reg <= return_from_interrupt_i & int_flag_reg & irq_pending_i;
    end
  end

  // Read data captured on a read strobe, unmapped reads give zero
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
    end else if (rd_en_i) begin
      rdata_reg <= (addr_i == `WDG_ADDR) ? reg_view : 8'h00;
    end
  end

  // Outputs straight from flops, apart from the constant pin level and reset vector
  assign rdata_o           = rdata_reg;
  assign rst_pin_o         = 1'b0;          // Open drain: only ever pulls low
  assign rst_pin_oe_o      = pin_drive_reg;
  assign cpu_rst_o         = cpu_rst_reg;
  assign stack_clear_o     = cpu_rst_reg;
  assign pc_load_o         = pc_load_reg;
  assign pc_vector_o       = `RESET_VECTOR;
  assign nmi_mode_o        = int_flag_reg;
  assign service_pending_o = service_reg;
  assign wait_mode_o       = state_reg[3];
  assign stop_mode_o       = state_reg[4];
  assign wdg_active_o      = c_eff;

endmodule // watchdog_and_reset_control

// ==== watchdog_and_reset_control_tb.sv ====
// Self-checking bench for the watchdog and reset controller
`timescale 1ns/1ns
module watchdog_and_reset_control_tb;
  reg         clk_i = 1'b0;
  reg         rst_n_i;
  reg         opt_hw_activation_i;
  reg         opt_ext_stop_i;
  reg         opt_lvd_en_i;
  reg         lvd_below_fall_i;
  reg         lvd_above_rise_i;
  reg         nmi_pin_i;
  reg         irq_pending_i;
  reg         ext_low;
  wire [7:0]  addr_i, wdata_i, rdata_o;
  wire [3:0]  ops;
  wire [11:0] pc_vector_o;
  wire        wr_en_i, rd_en_i, rst_pin_i, rst_pin_o, rst_pin_oe_o, stop_instr_i, wait_instr_i;
  wire        wake_irq_i, return_from_interrupt_i, cpu_rst_o, stack_clear_o, pc_load_o;
  wire        nmi_mode_o, service_pending_o, wait_mode_o, stop_mode_o, wdg_active_o;
  integer     n_checks = 0;
  integer     miscompares = 0;
  integer     i, k;
  reg [7:0]   rv;
  reg [47:0]  rows [0:4];
  always #4 clk_i = ~clk_i;
  // Wired-AND reset pin with pull-up
  assign rst_pin_i = !((rst_pin_oe_o && !rst_pin_o) || ext_low);
  assign {stop_instr_i, wait_instr_i, wake_irq_i, return_from_interrupt_i} = ops;
  watchdog_and_reset_control i_watchdog_and_reset_control (
    .clk_i, .rst_n_i, .addr_i, .wr_en_i, .rd_en_i, .wdata_i, .rdata_o, .opt_hw_activation_i,
    .opt_ext_stop_i, .opt_lvd_en_i, .lvd_below_fall_i, .lvd_above_rise_i, .rst_pin_i,
    .rst_pin_o, .rst_pin_oe_o, .nmi_pin_i, .stop_instr_i, .wait_instr_i, .wake_irq_i,
    .return_from_interrupt_i, .irq_pending_i, .cpu_rst_o, .stack_clear_o, .pc_load_o,
    .pc_vector_o, .nmi_mode_o, .service_pending_o, .wait_mode_o, .stop_mode_o, .wdg_active_o);
  cpu_model i_cpu_model (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .ops_o(ops));
  // Byte and bit comparisons
  task chk8(input string nm, input [7:0] e, input [7:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task chk1(input string nm, input e, input g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  // Bounded waits for reset release and for pin drive
  task wait_run;
    begin
      k = 0;
      while (cpu_rst_o !== 1'b0 && k < 5000) begin
        @(negedge clk_i);
        k = k + 1;
      end
      chk1("cpu_run", 1'b0, cpu_rst_o);
      chk1("pc_load", 1'b1, pc_load_o);
      chk1("vector", 1'b1, pc_vector_o === 12'hFFE);
    end
  endtask
  task wait_oe(input integer lim);
    begin
      k = 0;
      while (rst_pin_oe_o !== 1'b1 && k < lim) begin
        @(negedge clk_i);
        k = k + 1;
      end
      chk1("pin_drive", 1'b1, rst_pin_oe_o);
      chk1("pin_low", 1'b0, rst_pin_i);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Watchdog on the run length
  initial begin
    #400000;
    miscompares = miscompares + 1;
    end_sim;
  end
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    opt_hw_activation_i = 1'b0;
    opt_ext_stop_i = 1'b0;
    opt_lvd_en_i = 1'b0;
    lvd_below_fall_i = 1'b0;
    lvd_above_rise_i = 1'b1;
    nmi_pin_i = 1'b1;
    irq_pending_i = 1'b0;
    ext_low = 1'b0;
    rows[0] = {8'hD8, 8'hFE, 8'hD8, 16'h0000, 8'hFE};
    rows[1] = {8'hD8, 8'h82, 8'hD8, 16'h0C04, 8'h02};
    rows[2] = {8'hD8, 8'h82, 8'hD8, 16'h1806, 8'hFC};
    rows[3] = {8'hD9, 8'h00, 8'hD8, 16'h0000, 8'hFC};
    rows[4] = {8'hD9, 8'h00, 8'hD9, 16'h0000, 8'h00};
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    wait_run;
    i_cpu_model.rd(8'hD8, rv);
    chk8("reset_value", 8'hFE, rv);
    chk1("nmi_mode", 1'b1, nmi_mode_o);
    chk1("active", 1'b0, wdg_active_o);
    irq_pending_i = 1'b1;
    i_cpu_model.op(4'h1);
    chk1("service", 1'b1, service_pending_o);
    irq_pending_i = 1'b0;
    i_cpu_model.op(4'h8);
    chk1("stop_free", 1'b1, stop_mode_o);
    i_cpu_model.op(4'h2);
    chk1("woken", 1'b0, stop_mode_o);
    i_cpu_model.op(4'h4);
    chk1("wait_instr", 1'b1, wait_mode_o && !stop_mode_o);
    i_cpu_model.op(4'h2);
    chk1("wait_woken", 1'b0, wait_mode_o);
    for (i = 0; i < 5; i = i + 1) begin
      i_cpu_model.wr(rows[i][47:40], rows[i][39:32]);
      repeat (rows[i][23:8]) @(negedge clk_i);
      i_cpu_model.rd(rows[i][31:24], rv);
      chk8("row_read", rows[i][7:0], rv);
    end
    i_cpu_model.wr(8'hD8, 8'h03);
    chk1("active", 1'b1, wdg_active_o);
    i_cpu_model.wr(8'hD8, 8'h02);
    chk1("sticky", 1'b1, wdg_active_o);
    wait_oe(3200);
    chk1("timeout", 1'b1, k >= 3070 && k <= 3078);
    wait_run;
    i_cpu_model.rd(8'hD8, rv);
    chk8("reload", 8'hFE, rv);
    opt_lvd_en_i = 1'b1;
    i_cpu_model.wr(8'hD8, 8'hFC);
    wait_oe(4);
    wait_run;
    lvd_above_rise_i = 1'b0;
    lvd_below_fall_i = 1'b1;
    wait_oe(8);
    lvd_below_fall_i = 1'b0;
    repeat (300) @(negedge clk_i);
    chk1("lvd_held", 1'b1, cpu_rst_o);
    chk1("stack_clear", 1'b1, stack_clear_o);
    lvd_above_rise_i = 1'b1;
    wait_run;
    ext_low = 1'b1;
    repeat (3) @(negedge clk_i);
    opt_hw_activation_i = 1'b1;
    opt_ext_stop_i = 1'b1;
    repeat (3) @(negedge clk_i);
    ext_low = 1'b0;
    wait_run;
    chk1("hw_active", 1'b1, wdg_active_o);
    i_cpu_model.wr(8'hD8, 8'hFE);
    i_cpu_model.rd(8'hD8, rv);
    chk8("hw_ctrl", 8'hFF, rv);
    nmi_pin_i = 1'b0;
    i_cpu_model.op(4'h8);
    chk1("stop_wait", 1'b1, wait_mode_o && !stop_mode_o);
    i_cpu_model.op(4'h2);
    nmi_pin_i = 1'b1;
    i_cpu_model.op(4'h8);
    chk1("stop_ext", 1'b1, stop_mode_o);
    repeat (3100) @(negedge clk_i);
    i_cpu_model.rd(8'hD8, rv);
    chk8("frozen", 8'hFF, rv);
    i_cpu_model.op(4'h2);
    repeat (3100) @(negedge clk_i);
    i_cpu_model.rd(8'hD8, rv);
    chk8("resumed", 8'h7F, rv);
    end_sim;
  end
endmodule // watchdog_and_reset_control_tb

// ==== wdg_rst_assertions.sv ====
// Concurrent checks on the watchdog and reset controller ports
`timescale 1ns/1ns
module wdg_rst_assertions (
  input wire        clk_i,
  input wire        rst_n_i,
  input wire [7:0]  addr_i,
  input wire        wr_en_i,
  input wire [7:0]  wdata_i,
  input wire        opt_hw_activation_i,
  input wire        opt_ext_stop_i,
  input wire        opt_lvd_en_i,
  input wire        lvd_below_fall_i,
  input wire        rst_pin_oe_o,
  input wire        nmi_pin_i,
  input wire        stop_instr_i,
  input wire        return_from_interrupt_i,
  input wire        irq_pending_i,
  input wire        cpu_rst_o,
  input wire        pc_load_o,
  input wire [11:0] pc_vector_o,
  input wire        nmi_mode_o,
  input wire        service_pending_o,
  input wire        wait_mode_o,
  input wire        stop_mode_o,
  input wire        wdg_active_o
);
  reg  [15:0] oe_cnt;
  reg  [15:0] dly_cnt;
  wire        run;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Core executing with no reset source and no low-power mode
  assign run = !cpu_rst_o && !rst_pin_oe_o && !wait_mode_o && !stop_mode_o;
  // Lengths of pin drive and of the delay that follows it
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_cnt  <= 16'h0000;
      dly_cnt <= 16'h0000;
    end else begin
      oe_cnt  <= rst_pin_oe_o ? oe_cnt + 16'h0001 : 16'h0000;
      dly_cnt <= (cpu_rst_o && !rst_pin_oe_o) ? dly_cnt + 16'h0001 : 16'h0000;
    end
  end
  sequence s_int_rst;
    rst_pin_oe_o && cpu_rst_o;
  endsequence
  sequence s_stop_req;
    stop_instr_i && run;
  endsequence
  property p_soft_reset;
    wr_en_i && addr_i == 8'hD8 && !wdata_i[1] && run |-> ##[1:2] s_int_rst;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset write missed");
  property p_lvd_hold;
    opt_lvd_en_i && lvd_below_fall_i |-> ##[1:2] s_int_rst;
  endproperty
  a_lvd_hold: assert property (p_lvd_hold)
    else $error("low supply not holding reset");
  property p_stretch;
    $fell(rst_pin_oe_o) |-> oe_cnt >= 16'h000F;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("reset pin drive too short");
  property p_delay;
    $fell(cpu_rst_o) |-> dly_cnt >= 16'h07FF && nmi_mode_o;
  endproperty
  a_delay: assert property (p_delay)
    else $error("stabilisation delay too short");
  property p_vector;
    pc_load_o |-> !cpu_rst_o && $past(cpu_rst_o) && pc_vector_o == 12'hFFE;
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector load wrong");
  property p_flag_clear;
    return_from_interrupt_i && run |=>
      !nmi_mode_o && service_pending_o == $past(nmi_mode_o && irq_pending_i);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("return handling wrong");
  property p_stop_free;
    s_stop_req ##0 !wdg_active_o |=> stop_mode_o;
  endproperty
  a_stop_free: assert property (p_stop_free)
    else $error("stop refused with watchdog idle");
  property p_stop_ext;
    s_stop_req ##0 opt_hw_activation_i && opt_ext_stop_i && nmi_pin_i |=> stop_mode_o;
  endproperty
  a_stop_ext: assert property (p_stop_ext)
    else $error("external stop refused");
  property p_stop_gate;
    s_stop_req ##0 wdg_active_o && !(opt_hw_activation_i && opt_ext_stop_i && nmi_pin_i)
      |=> wait_mode_o && !stop_mode_o;
  endproperty
  a_stop_gate: assert property (p_stop_gate)
    else $error("stop not turned into wait");
  property p_hw_active;
    opt_hw_activation_i && !cpu_rst_o |-> wdg_active_o;
  endproperty
  a_hw_active: assert property (p_hw_active)
    else $error("hardware option not active");
endmodule // wdg_rst_assertions

bind watchdog_and_reset_control wdg_rst_assertions i_wdg_rst_assertions (
  .clk_i, .rst_n_i, .addr_i, .wr_en_i, .wdata_i, .opt_hw_activation_i, .opt_ext_stop_i,
  .opt_lvd_en_i, .lvd_below_fall_i, .rst_pin_oe_o, .nmi_pin_i, .stop_instr_i,
  .return_from_interrupt_i, .irq_pending_i, .cpu_rst_o, .pc_load_o, .pc_vector_o,
  .nmi_mode_o, .service_pending_o, .wait_mode_o, .stop_mode_o, .wdg_active_o);

// ==== wdg_rst_defs.vh ====
// Constants for the watchdog and reset controller
`ifndef WDG_RST_DEFS_VH
`define WDG_RST_DEFS_VH

// Data-space location and reset image of the watchdog register
`define WDG_ADDR            8'hD8
`define WDG_RESET_VAL       8'hFE

// Field positions inside the watchdog register
`define WDG_C_BIT           0
`define WDG_SR_BIT          1
`define WDG_T5_BIT          2
`define WDG_T0_BIT          7

// Physical counter reset value and the bit that ends the count
`define WDG_CNT_RESET       7'h7F
`define WDG_CNT_TOP_BIT     6

// Clocks per counter decrement and the last prescaler state
`define WDG_PRESCALE        12'hC00
`define WDG_PRESCALE_LAST   12'hBFF

// Last stretch count of the reset state, which is held at least 16 clocks
`define RST_STRETCH_LAST    5'h0F

// Last count of the built-in stabilisation delay after reset, which lasts 2048 clocks
`define STAB_DELAY_LAST     12'h7FF

// Reset vector address loaded into the program counter
`define RESET_VECTOR        12'hFFE

`endif

// ==== wdt_prescaler.v ====
// Divider that produces one tick per watchdog decrement period
`timescale 1ns/1ns
`include "wdg_rst_defs.vh"

module wdt_prescaler (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        clear_i,
  input  wire        run_i,
  output reg         tick_o
);

  reg  [11:0] div_reg;
  reg  [11:0] div_next;
  reg         tick_next;

  // Count while running, hold while frozen, restart on clear
  always @* begin
    div_next  = div_reg;
    tick_next = 1'b0;
    if (clear_i) begin
      div_next = 12'h000;
    end else if (run_i) begin
      if (div_reg == `WDG_PRESCALE_LAST) begin
        div_next  = 12'h000;
        tick_next = 1'b1;
      end else begin
        div_next = div_reg + 12'h001;
      end
    end
  end

  // Divider state and tick flop
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= 12'h000;
      tick_o  <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_o  <= tick_next;
    end
  end

endmodule // wdt_prescaler
